// file: inc/lcd_pkg.sv
// package: register map, field layout, types and helpers of the lcd driver
`default_nettype none
package lcd_pkg;
  // ==========================================================
  // register and display memory map
  localparam logic [11:0] DRV_VOLT_ADDR = 12'h00FC; // voltage select
  localparam logic [11:0] DISP_CTL_ADDR = 12'h00FD; // display control
  localparam logic [11:0] RAM_FIRST     = 12'h0830; // frontplane 0 byte
  localparam logic [11:0] RAM_LAST      = 12'h0845; // frontplane 21 byte
  localparam int          NUM_FRONT     = 22;       // frontplane lines
  localparam int          NUM_BACK      = 8;        // backplane lines
  localparam int          NUM_SHARED    = 6;        // shared plane pins
  localparam int          SHARED_BASE   = 2;        // first shared backplane
  localparam logic [7:0]  CTL_RESET     = 8'h00;    // display control reset
  localparam logic [7:0]  VOLT_RESET    = 8'h00;    // voltage select reset
  // ==========================================================
  // display control field positions
  localparam int ON_BIT    = 0; // display on
  localparam int BIAS_LSB  = 1; // bias type, 2 bits, 0 = none
  localparam int DUTY_LSB  = 3; // duty, 2 bits
  localparam int CLK_LSB   = 5; // scan clock select, 2 bits
  // ==========================================================
  // scan clock: 128 Hz is one step per 256 watch clock edges
  localparam logic [7:0] DIV_BASE = 8'hFF; // last count at 128 Hz
  // ==========================================================
  // duty codes
  typedef enum logic [1:0] {
    duty_8 = 2'b00,
    duty_4 = 2'b01,
    duty_3 = 2'b10,
    duty_2 = 2'b11
  } duty_t;
  // scan states, gray along off -> sync -> scan
  typedef enum logic [1:0] {
    st_off  = 2'b00,
    st_sync = 2'b01,
    st_scan = 2'b11
  } scan_st_t;
  // ==========================================================
  // processor access request
  typedef struct packed {
    logic [11:0] addr;    // page and offset
    logic        wr;      // write strobe
    logic        rd;      // read strobe
    logic        bit_op;  // single-bit access
    logic [2:0]  bit_sel; // bit index for bit access
    logic [7:0]  wdata;   // byte, or bit in wdata[0]
  } cpu_req_t;
  // panel drive outputs
  typedef struct packed {
    logic [7:0]  backplane_lines;  // active common lines
    logic [21:0] frontplane_lines; // 1 = select waveform
    logic [5:0]  shared_is_back;   // shared pin acts as common
    logic        panel_on;         // drivers active
    logic        frame_phase;      // toggles each frame
    logic [1:0]  bias_type;        // bias network select
    logic [7:0]  drive_volt_sel;   // drive voltage code
  } panel_t;
  // ==========================================================
  // number of commons scanned for a duty
  function automatic logic [3:0] com_count(input duty_t d);
    case (d)
      duty_4:  com_count = 4'h4;
      duty_3:  com_count = 4'h3;
      duty_2:  com_count = 4'h2;
      default: com_count = 4'h8;
    endcase
  endfunction
  // first frontplane line in use for a duty
  function automatic logic [4:0] first_front(input duty_t d);
    case (d)
      duty_4:  first_front = 5'h02;
      duty_3:  first_front = 5'h01;
      duty_2:  first_front = 5'h00;
      default: first_front = 5'h06;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: core/lcd_segment_common_driver.sv
// module: multiplexed lcd driver with display memory and control registers
`timescale 1ns/1ns
`default_nettype none
module lcd_segment_common_driver (
  // clock, reset, enable
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // processor register and memory access
  input  wire lcd_pkg::cpu_req_t cpu_req,
  output var  logic [7:0]       cpu_rdata,
  // watch timer clock and power state
  input  wire logic             watch_clock,
  input  wire logic             sub_clk_src,
  input  wire logic             cpu_idle,
  // panel drive
  output var  lcd_pkg::panel_t  panel
);
  // ==========================================================
  // state of the whole block
  typedef struct packed {
    logic [7:0]          ctl;      // display control register
    logic [7:0]          volt;     // drive voltage select register
    logic [21:0][7:0]    ram;      // display memory
    logic                ws1;      // watch clock sync stage 1
    logic                ws2;      // watch clock sync stage 2
    logic                ws3;      // edge detect delay
    lcd_pkg::scan_st_t   st;       // scan state
    logic [7:0]          div;      // scan clock divider
    logic [2:0]          com;      // current common
    logic                phase;    // frame phase
    logic [7:0]          rdata;    // read data
    lcd_pkg::panel_t     pan;      // panel outputs
  } state_t;

  state_t s_reg;   // registered state
  state_t s_next;  // next state

  // ==========================================================
  // decode helpers
  logic        ram_hit;    // access falls in display memory
  logic [4:0]  ram_idx;    // memory byte index
  logic        ctl_hit;    // display control selected
  logic        volt_hit;   // voltage select selected
  logic [7:0]  old_byte;   // current value at address
  logic [7:0]  new_byte;   // value to write
  logic        rise;       // synced watch clock edge
  logic        scan_ok;    // scanning allowed in this power state
  logic [7:0]  div_last;   // divider terminal count
  logic [3:0]  ncom;       // commons in use
  logic [4:0]  first;      // first frontplane in use
  lcd_pkg::duty_t duty;    // decoded duty

  // ==========================================================
  // address decode and read value
  always_comb begin
    ram_hit  = (cpu_req.addr >= lcd_pkg::RAM_FIRST) &&
               (cpu_req.addr <= lcd_pkg::RAM_LAST);
    ram_idx  = 5'(cpu_req.addr - lcd_pkg::RAM_FIRST);
    ctl_hit  = (cpu_req.addr == lcd_pkg::DISP_CTL_ADDR);
    volt_hit = (cpu_req.addr == lcd_pkg::DRV_VOLT_ADDR);
    if (ram_hit) begin
      old_byte = s_reg.ram[ram_idx];
    end else if (ctl_hit) begin
      old_byte = s_reg.ctl;
    end else if (volt_hit) begin
      old_byte = s_reg.volt;
    end else begin
      old_byte = 8'h00;
    end
    // bit access replaces one bit, byte access the whole byte
    new_byte = cpu_req.wdata;
    if (cpu_req.bit_op) begin
      new_byte = old_byte;
      new_byte[cpu_req.bit_sel] = cpu_req.wdata[0];
    end
  end

  // ==========================================================
  // mode decode from the registered control byte
  always_comb begin
    duty     = lcd_pkg::duty_t'(s_reg.ctl[lcd_pkg::DUTY_LSB +: 2]);
    ncom     = lcd_pkg::com_count(duty);
    first    = lcd_pkg::first_front(duty);
    div_last = lcd_pkg::DIV_BASE >>
               s_reg.ctl[lcd_pkg::CLK_LSB +: 2];
    rise     = s_reg.ws2 & ~s_reg.ws3;
    // with the sub clock as source the scan ignores idle
    scan_ok  = sub_clk_src | ~cpu_idle;
  end

  // ==========================================================
  // next state
  always_comb begin
    s_next = s_reg;
    // watch clock synchroniser and edge delay
    s_next.ws1 = watch_clock;
    s_next.ws2 = s_reg.ws1;
    s_next.ws3 = s_reg.ws2;
    // read returns the addressed byte, zero when unmapped
    if (cpu_req.rd) begin
      s_next.rdata = old_byte;
    end
    // writes: memory bytes are plain storage in every mode
    if (cpu_req.wr && ram_hit) begin
      s_next.ram[ram_idx] = new_byte;
    end
    if (cpu_req.wr && volt_hit) begin
      s_next.volt = new_byte;
    end
    // scan sequencing
    case (s_reg.st)
      lcd_pkg::st_off: begin
        // no scanning while off
        s_next.div = 8'h00;
        s_next.com = 3'h0;
        if (s_reg.ctl[lcd_pkg::ON_BIT]) begin
          s_next.st = lcd_pkg::st_sync;
        end
      end
      lcd_pkg::st_sync: begin
        // start a fresh frame at common 0
        s_next.div   = 8'h00;
        s_next.com   = 3'h0;
        s_next.phase = 1'b0;
        s_next.st    = lcd_pkg::st_scan;
      end
      lcd_pkg::st_scan: begin
        if (!s_reg.ctl[lcd_pkg::ON_BIT]) begin
          s_next.st = lcd_pkg::st_off;
        end else if (rise && scan_ok) begin
          // edges arrive only while the watch timer runs
          if (s_reg.div == div_last) begin
            s_next.div = 8'h00;
            // each common holds one equal scan slot
            if ({1'b0, s_reg.com} == ncom - 4'h1) begin
              s_next.com   = 3'h0;
              s_next.phase = ~s_reg.phase;
            end else begin
              s_next.com = s_reg.com + 3'h1;
            end
          end else begin
            s_next.div = s_reg.div + 8'h01;
          end
        end
      end
      default: begin
        s_next.st = lcd_pkg::st_off;
      end
    endcase
    // any control write restarts clock and duty sequencing
    if (cpu_req.wr && ctl_hit) begin
      s_next.ctl = new_byte;
      s_next.st  = new_byte[lcd_pkg::ON_BIT] ?
                   lcd_pkg::st_sync : lcd_pkg::st_off;
      s_next.div = 8'h00;
      s_next.com = 3'h0;
    end
    // panel scan outputs follow the next state; bias, voltage and shared pins follow s_reg
    s_next.pan = '0;
    s_next.pan.bias_type      = s_reg.ctl[lcd_pkg::BIAS_LSB +: 2];
    s_next.pan.drive_volt_sel = s_reg.volt;
    for (int j = 0; j < lcd_pkg::NUM_SHARED; j++) begin
      // shared pins become commons when the duty needs them
      s_next.pan.shared_is_back[j] =
        (4'(j + lcd_pkg::SHARED_BASE) < ncom);
    end
    if (s_next.st == lcd_pkg::st_scan) begin
      s_next.pan.panel_on    = 1'b1;
      s_next.pan.frame_phase = s_next.phase;
      // one common active at a time
      s_next.pan.backplane_lines[s_next.com] = 1'b1;
      for (int k = 0; k < lcd_pkg::NUM_FRONT; k++) begin
        // memory fetched every cycle, bit n for common n
        if (5'(k) >= first) begin
          s_next.pan.frontplane_lines[k] =
            s_next.ram[k][s_next.com];
        end
      end
    end
  end

  // ==========================================================
  // state register; enable low freezes everything
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  always_comb begin
    cpu_rdata = s_reg.rdata;
    panel     = s_reg.pan;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // reset leaves both registers cleared
  property p_reset_clear;
    @(posedge core_clk) disable iff (1'b0)
    !rstn |=> (s_reg.ctl == 8'h00) && (s_reg.volt == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("registers not cleared by reset");

  // off means idle outputs
  property p_off_idle;
    s_reg.st != lcd_pkg::st_scan |->
      (panel.backplane_lines == 8'h00) &&
      (panel.frontplane_lines == 22'h00_0000) && !panel.panel_on;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("outputs driven while display off");

  // control write restarts the sequence
  property p_restart;
    ce && cpu_req.wr && !cpu_req.bit_op &&
    (cpu_req.addr == lcd_pkg::DISP_CTL_ADDR) && cpu_req.wdata[0]
    |=> (s_reg.st == lcd_pkg::st_sync) && (s_reg.com == 3'h0)
        ##1 (ce -> (s_reg.com == 3'h0));
  endproperty
  a_restart: assert property (p_restart)
    else $error("control write did not restart scanning");

  // exactly one common active while scanning
  property p_onehot;
    s_reg.st == lcd_pkg::st_scan |->
      $onehot(panel.backplane_lines) &&
      ({1'b0, s_reg.com} < ncom);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("common selection out of range");

  // segment data follows memory bit for the active common
  property p_fetch;
    (s_reg.st == lcd_pkg::st_scan) && (duty == lcd_pkg::duty_2) |->
      panel.frontplane_lines[21] == s_reg.ram[21][s_reg.com] &&
      panel.frontplane_lines[0] == s_reg.ram[0][s_reg.com];
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("segment data does not match memory");

  // quarter duty leaves lines 0 and 1 unused
  property p_quarter;
    (s_reg.st == lcd_pkg::st_scan) && (duty == lcd_pkg::duty_4) |->
      (panel.frontplane_lines[1:0] == 2'b00) &&
      (panel.shared_is_back == 6'h03);
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("quarter duty pin use wrong");

  // eighth duty turns every shared pin into a common
  property p_eighth;
    (s_reg.st == lcd_pkg::st_scan) && (duty == lcd_pkg::duty_8) |->
      (panel.shared_is_back == 6'h3F) &&
      (panel.frontplane_lines[5:0] == 6'h00);
  endproperty
  a_eighth: assert property (p_eighth)
    else $error("eighth duty pin use wrong");

  // idle on main clock source halts the scan
  property p_idle_hold;
    (s_reg.st == lcd_pkg::st_scan) && cpu_idle && !sub_clk_src &&
    !cpu_req.wr |=> $stable(s_reg.com) && $stable(s_reg.div);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("scan advanced while idle on main source");

  // byte read returns the stored memory byte one cycle later
  property p_read;
    ce && cpu_req.rd && ram_hit |=>
      cpu_rdata == $past(s_reg.ram[ram_idx]);
  endproperty
  a_read: assert property (p_read)
    else $error("memory read data wrong");

  // third duty frees only line 0 and shares one pin
  property p_third;
    (s_reg.st == lcd_pkg::st_scan) && (duty == lcd_pkg::duty_3) |->
      (panel.frontplane_lines[0] == 1'b0) &&
      (panel.shared_is_back == 6'h01);
  endproperty
  a_third: assert property (p_third)
    else $error("third duty pin use wrong");

  // half duty keeps every shared pin a segment
  property p_half;
    (s_reg.st == lcd_pkg::st_scan) && (duty == lcd_pkg::duty_2) |->
      (panel.shared_is_back == 6'h00) && (s_reg.com < 3'h2);
  endproperty
  a_half: assert property (p_half)
    else $error("half duty pin use wrong");

  // voltage select reaches the panel one cycle later
  property p_volt_mirror;
    ce |=> panel.drive_volt_sel == $past(s_reg.volt);
  endproperty
  a_volt_mirror: assert property (p_volt_mirror)
    else $error("drive voltage select not mirrored");

  // commons hold between watch clock edges
  property p_step;
    (s_reg.st == lcd_pkg::st_scan) && !rise && !(cpu_req.wr && ctl_hit)
    |=> $stable(s_reg.com);
  endproperty
  a_step: assert property (p_step)
    else $error("common moved without a scan clock edge");

  // off state keeps the scan counters parked
  property p_off_still;
    s_reg.st == lcd_pkg::st_off |-> (s_reg.div == 8'h00) &&
      (s_reg.com == 3'h0);
  endproperty
  a_off_still: assert property (p_off_still)
    else $error("scan counters moved while display off");

endmodule
`default_nettype wire

// file: dv/lcd_glass_model.sv
// passive panel model: watches the commons and flags bad scan order
`timescale 1ns/1ns
`default_nettype none
module lcd_glass_model (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rstn,
  // panel drive from the device
  input  wire lcd_pkg::panel_t panel,
  // order fault count
  output var  logic [7:0]      order_faults
);
  logic [7:0] last_back; // last common seen active
  // ==========================================================
  // commons one at a time, next one up or back to common 0
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      last_back    <= 8'h00;
      order_faults <= 8'h00;
    end else if (panel.backplane_lines !== last_back) begin
      // a new common must be one-hot and follow its neighbour
      if (panel.backplane_lines !== 8'h00 &&
          panel.backplane_lines !== 8'h01 &&
          panel.backplane_lines !== (last_back << 1)) begin
        order_faults <= order_faults + 8'h01;
      end
      last_back <= panel.backplane_lines;
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// testbench: registers, display memory, duty scan, idle and restart
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic              core_clk = 1'b0;    // 250 MHz core clock
  logic              rstn = 1'b0;        // synchronous reset, low
  logic              ce = 1'b1;          // clock enable
  lcd_pkg::cpu_req_t cpu_req = '0;       // processor access
  logic [7:0]        cpu_rdata;          // read data
  logic              watch_clock = 1'b0; // watch timer clock
  logic              sub_clk_src = 1'b0; // sub clock as scan source
  logic              cpu_idle = 1'b0;    // main clock stopped
  lcd_pkg::panel_t   panel;              // panel drive
  logic [7:0]        order_faults;       // from the glass model
  logic [7:0]        mem [0:21];         // expected display bytes
  int                fail_count = 0;     // mismatches
  int                samples_checked = 0; // comparisons
  // ==========================================================
  // clocks: watch clock unrelated in phase, 8 core cycles a period
  always #2 core_clk = ~core_clk;
  initial #3 forever #16 watch_clock = ~watch_clock;
  lcd_segment_common_driver uut (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .watch_clock(watch_clock),
    .sub_clk_src(sub_clk_src), .cpu_idle(cpu_idle), .panel(panel));
  lcd_glass_model glass (
    .core_clk(core_clk), .rstn(rstn), .panel(panel),
    .order_faults(order_faults));
  // ==========================================================
  // shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access, one cycle strobe, then one idle cycle before the next
  task automatic acc(input logic [11:0] a, input logic w,
                     input logic [7:0] d, input logic b,
                     input logic [2:0] s);
    cpu_req.addr = a;
    cpu_req.wr = w;
    cpu_req.rd = ~w;
    cpu_req.wdata = d;
    cpu_req.bit_op = b;
    cpu_req.bit_sel = s;
    @(negedge core_clk);
    cpu_req.wr = 1'b0;
    cpu_req.rd = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    acc(a, 1'b0, 8'h00, 1'b0, 3'h0);
    chk(cpu_rdata, exp);
  endtask
  // wait for the common to move on, then compare it
  task automatic next_back(input logic [7:0] exp);
    logic [7:0] prev;
    prev = panel.backplane_lines;
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (panel.backplane_lines !== prev) break;
      if (i == 2999) begin
        fail_count++;
        end_sim();
      end
    end
    chk(panel.backplane_lines, exp);
  endtask
  // expected frontplane for a duty and common, lines below first 0
  function automatic logic [21:0] front(input int first, input int n);
    front = 22'h00_0000;
    for (int k = first; k < 22; k++) front[k] = mem[k][n];
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(panel.backplane_lines, 8'h00);
    chk(panel.frontplane_lines, 22'h00_0000);
    chk(panel.panel_on, 1'b0);
    chk(panel.shared_is_back, 6'h3F);
    chk(panel.bias_type, 2'h0);
    chk(panel.drive_volt_sel, 8'h00);
    rd(lcd_pkg::DISP_CTL_ADDR, 8'h00);
    rd(lcd_pkg::DRV_VOLT_ADDR, 8'h00);
    acc(lcd_pkg::DRV_VOLT_ADDR, 1'b1, 8'h5A, 1'b0, 3'h0);
    rd(lcd_pkg::DRV_VOLT_ADDR, 8'h5A);
    chk(panel.drive_volt_sel, 8'h5A);
    rd(12'h0123, 8'h00);
  endtask
  task automatic t_memory();
    for (int k = 0; k < 22; k++) begin
      mem[k] = 8'(k * 8'h25 + 8'h13);
      acc(12'(lcd_pkg::RAM_FIRST + k), 1'b1, mem[k], 1'b0, 3'h0);
    end
    acc(12'h0832, 1'b1, 8'h01, 1'b1, 3'h6);
    mem[2][6] = 1'b1;
    acc(12'h0833, 1'b1, 8'h00, 1'b1, 3'h0);
    mem[3][0] = 1'b0;
    for (int k = 0; k < 22; k++)
      rd(12'(lcd_pkg::RAM_FIRST + k), mem[k]);
    rd(12'h0846, 8'h00);
  endtask
  // every duty: check every slot, wrap, shared pins
  task automatic t_duty();
    int ncom [4] = '{8, 4, 3, 2};
    int first [4] = '{6, 2, 1, 0};
    logic [5:0] shr [4] = '{6'h3F, 6'h03, 6'h01, 6'h00};
    for (int d = 0; d < 4; d++) begin
      acc(lcd_pkg::DISP_CTL_ADDR, 1'b1, 8'(8'h61 | (d << 3)), 1'b0, 3'h0);
      repeat (3) @(negedge core_clk);
      chk(panel.backplane_lines, 8'h01);
      chk(panel.frontplane_lines, front(first[d], 0));
      chk(panel.shared_is_back, shr[d]);
      for (int n = 1; n < ncom[d]; n++) begin
        next_back(8'(1 << n));
        chk(panel.frontplane_lines, front(first[d], n));
      end
      next_back(8'h01);
      chk(panel.frame_phase, 1'b1);
    end
  endtask
  task automatic t_idle();
    acc(lcd_pkg::DISP_CTL_ADDR, 1'b1, 8'h79, 1'b0, 3'h0);
    cpu_idle = 1'b1;
    repeat (600) @(negedge core_clk);
    chk(panel.backplane_lines, 8'h01);
    sub_clk_src = 1'b1;
    next_back(8'h02);
    next_back(8'h01);
    chk(panel.frame_phase, 1'b1);
    next_back(8'h02);
    cpu_idle = 1'b0;
    sub_clk_src = 1'b0;
    // same value again restarts at common 0 with phase cleared
    acc(lcd_pkg::DISP_CTL_ADDR, 1'b1, 8'h79, 1'b0, 3'h0);
    repeat (3) @(negedge core_clk);
    chk(panel.backplane_lines, 8'h01);
    chk(panel.frame_phase, 1'b0);
  endtask
  // capacitor bias, settle, then on, then off again
  task automatic t_bias_off();
    acc(lcd_pkg::DISP_CTL_ADDR, 1'b1, 8'h02, 1'b0, 3'h0);
    repeat (3) @(negedge core_clk);
    chk(panel.bias_type, 2'h1);
    chk(panel.backplane_lines, 8'h00);
    repeat (100) @(negedge core_clk);
    acc(lcd_pkg::DISP_CTL_ADDR, 1'b1, 8'h01, 1'b1, 3'h0);
    repeat (3) @(negedge core_clk);
    chk(panel.panel_on, 1'b1);
    // slowest scan clock: no step long before 256 watch edges
    repeat (1900) @(negedge core_clk);
    chk(panel.backplane_lines, 8'h01);
    next_back(8'h02);
    rd(lcd_pkg::DISP_CTL_ADDR, 8'h03);
    acc(lcd_pkg::DISP_CTL_ADDR, 1'b1, 8'h00, 1'b0, 3'h0);
    repeat (3) @(negedge core_clk);
    chk(panel.backplane_lines, 8'h00);
    chk(panel.frontplane_lines, 22'h00_0000);
  endtask
  // ==========================================================
  // main sequence; watch clock runs all along
  initial begin
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_memory();
    t_duty();
    t_idle();
    t_bias_off();
    chk(order_faults, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
